// File: pkg/g1a_pkg.sv
// shared constants and types for the group 1 alias register block
package g1a_pkg;
    localparam int        ADDR_W        = 8;
    localparam int        DATA_W        = 32;
    localparam int        BP_W          = 3;
    localparam int        PRIO_W        = 8;
    localparam int        ID_W          = 10;
    localparam int        CPU_W         = 3;
    localparam int        CPU_POS       = 10;
    localparam int        COMMON_SPLIT_SELECT_POS      = 0;

    localparam logic [ADDR_W-1:0] OFF_CTRL      = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SPLIT     = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_ACK       = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_ALIAS     = 8'h1c;
    localparam logic [ADDR_W-1:0] OFF_ACK_ALIAS = 8'h20;

    // smallest binary point of the secure copy; alias resets one above it
    localparam logic [BP_W-1:0]   BP_MIN_DEF    = 3'h2;
    localparam logic [BP_W-1:0]   BP_ONE        = 3'h1;
    localparam logic              RST_COMMON_SPLIT_SELECT      = 1'b0;
    localparam logic [ID_W-1:0]   ID_SPURIOUS   = 10'h3ff;
    localparam logic [ID_W-1:0]   ID_SGI_LIMIT  = 10'h010;
    localparam logic [DATA_W-1:0] RD_ZERO       = 32'h0000_0000;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_DONE = 2'b10
    } g1a_state_t;
endpackage

// File: src/g1a_split_map.sv
// maps a binary point onto the mask of group priority bits
`timescale 1ns/1ps
module g1a_split_map
    import g1a_pkg::*;
(
    input  wire logic [BP_W-1:0]   binPoint,
    input  wire logic              sepMap,
    output logic      [PRIO_W-1:0] groupMask
);
    // standard: bits [7:bp+1] decide preemption
    // separate: bits [7:bp], with bp 0 treated like bp 1
    logic [BP_W-1:0] lowBit;
    logic [3:0]      stdLow;
    logic [3:0]      effLow;

    assign lowBit = (binPoint == 3'h0) ? BP_ONE : binPoint;
    assign stdLow = {1'b0, binPoint} + 4'h1;
    assign effLow = sepMap ? {1'b0, lowBit} : stdLow;

    generate
        for (genvar i = 0; i < PRIO_W; i++) begin : g_bit
            assign groupMask[i] = (4'(i) >= effLow);
        end
    endgenerate
endmodule

// File: src/g1a_ack_port.sv
// acknowledge path: builds the returned word and strobes the core
`timescale 1ns/1ps
module g1a_ack_port
    import g1a_pkg::*;
#(
    parameter bit MULTI_CPU = 1'b1
)(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              takeAck,
    input  wire logic              group1Only,
    input  wire logic              sigValid,
    input  wire logic              sigGroup1,
    input  wire logic [ID_W-1:0]   sigId,
    input  wire logic [CPU_W-1:0]  sigCpu,
    output logic      [DATA_W-1:0] ackWord,
    output logic                   ackStrobe,
    output logic      [ID_W-1:0]   ackId
);
    logic            hit;
    logic            isSgi;
    logic [CPU_W-1:0] cpuField;

    // a group 0 interrupt is not visible through the group 1 views
    assign hit      = sigValid && (sigGroup1 || !group1Only);
    assign isSgi    = sigId < ID_SGI_LIMIT;
    assign cpuField = (MULTI_CPU && isSgi) ? sigCpu : 3'h0;
    assign ackWord  = hit ? {19'h0, cpuField, sigId}
                          : {22'h0, ID_SPURIOUS};

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ackStrobe <= 1'b0;
            ackId     <= 10'h000;
        end else begin
            ackStrobe <= takeAck && hit;
            ackId     <= sigId;
        end
    end
endmodule

// File: src/g1a_regs.sv
// group 1 aliased cpu interface registers behind an avalon-mm slave
//
// Chosen here: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
// Function
// - the alias binary point resets to one above the smallest supported value.
// - with security support both aliases answer secure accesses only.
// - with security support the alias and non-secure split register share storage.
// - alias accesses behave the same whatever the common split select bit is.
// - with grouping and common split select set the alias does not steer group 1 preemption.
// - an alias that is not implemented reads zero and ignores writes.
// - the 3-bit binary point splits the 8-bit priority into group and subpriority.
// - group 1 with grouping and common split select uses the separate mapping.
// - the binary point alias exists only in version 2 or version 1 with security.
// - the acknowledge alias exists only in version 2.
// - reading the acknowledge alias returns the signalled group 1 interrupt id.
// - an acknowledge alias read that returns a group 1 interrupt id also acknowledges that interrupt.
// - a secure acknowledge alias access equals a non-secure normal acknowledge.
// - ids sit in bits 9:0 and bits 12:10 carry the requester only for sgis.
module g1a_regs
    import g1a_pkg::*;
#(
    parameter int           VERSION   = 2,
    parameter bit           SEC_EXT   = 1'b1,
    parameter bit           GROUPING  = 1'b1,
    parameter bit           MULTI_CPU = 1'b1,
    parameter logic [2:0]   BP_MIN    = BP_MIN_DEF
)(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [DATA_W-1:0] writedata,
    output logic      [DATA_W-1:0] readdata,
    output logic                   waitrequest,
    input  wire logic              secureAccess,
    input  wire logic              sigValid,
    input  wire logic              sigGroup1,
    input  wire logic [ID_W-1:0]   sigId,
    input  wire logic [CPU_W-1:0]  sigCpu,
    output logic                   ackStrobe,
    output logic      [ID_W-1:0]   ackId,
    output logic      [PRIO_W-1:0] group1PreemptMask,
    output logic      [PRIO_W-1:0] group0PreemptMask
);
    localparam logic [BP_W-1:0] ALIAS_RST = BP_MIN + BP_ONE;
    localparam bit ALIAS_PRESENT = (VERSION == 2) || SEC_EXT;
    localparam bit ACK_ALIAS_PRESENT = (VERSION == 2);

    // saturate a written binary point at the floor of its copy
    function automatic logic [BP_W-1:0] clampBp(
        input logic [DATA_W-1:0] data,
        input logic [BP_W-1:0]   floorVal
    );
        logic [BP_W-1:0] field;
        field = data[BP_W-1:0];
        return (field < floorVal) ? floorVal : field;
    endfunction

    g1a_state_t      state_q;
    g1a_state_t      state_d;
    logic [BP_W-1:0] nsBp_q;
    logic [BP_W-1:0] nsBp_d;
    logic [BP_W-1:0] sBp_q;
    logic [BP_W-1:0] sBp_d;
    logic            common_split_select_q;
    logic            common_split_select_d;
    logic [DATA_W-1:0] rdData_q;
    logic [DATA_W-1:0] rdData_d;
    logic [PRIO_W-1:0] g1Mask_q;
    logic [PRIO_W-1:0] g0Mask_q;
    logic            firstCycle_q;

    logic            take;
    logic            takeRd;
    logic            takeWr;
    logic            hitCtrl;
    logic            hitSplit;
    logic            hitAck;
    logic            hitAlias;
    logic            hitAckAlias;
    logic            secView;
    logic            aliasOpen;
    logic            ackAliasOpen;
    logic            splitSecure;
    logic            ctrlWrOk;
    logic            takeAck;
    logic            group1Only;
    logic [DATA_W-1:0] ackWord;
    logic [BP_W-1:0]   splitView;
    logic [BP_W-1:0]   g1Bp;
    logic              g1SepMap;
    logic [PRIO_W-1:0] g1MaskComb;
    logic [PRIO_W-1:0] g0MaskComb;

    // bus handshake: a request is taken in idle and answered one cycle on
    assign take        = (state_q == ST_IDLE) && (read || write);
    assign takeRd      = take && read;
    assign takeWr      = take && write;
    assign waitrequest = (state_q == ST_IDLE) && (read || write);
    assign state_d     = take ? ST_DONE : ST_IDLE;

    assign hitCtrl     = address == OFF_CTRL;
    assign hitSplit    = address == OFF_SPLIT;
    assign hitAck      = address == OFF_ACK;
    assign hitAlias    = address == OFF_ALIAS;
    assign hitAckAlias = address == OFF_ACK_ALIAS;

    // without security extensions every access sees the secure view
    assign secView      = !SEC_EXT || secureAccess;
    assign aliasOpen    = ALIAS_PRESENT && secView;
    assign ackAliasOpen = ACK_ALIAS_PRESENT && secView;
    assign splitSecure  = secView;
    assign ctrlWrOk     = secView;

    // secure alias read is the non-secure normal acknowledge
    assign takeAck    = takeRd && (hitAck || (hitAckAlias && ackAliasOpen));
    assign group1Only = hitAckAlias || (SEC_EXT && !secureAccess);

    assign splitView = splitSecure ? sBp_q : nsBp_q;

    // the alias path ignores common_split_select; only preemption selection looks at it
    always_comb begin
        nsBp_d = nsBp_q;
        if (takeWr && hitAlias && aliasOpen) begin
            nsBp_d = clampBp(writedata, ALIAS_RST);
        end else if (takeWr && hitSplit && !splitSecure) begin
            nsBp_d = clampBp(writedata, ALIAS_RST);
        end
    end

    always_comb begin
        sBp_d = sBp_q;
        if (takeWr && hitSplit && splitSecure) begin
            sBp_d = clampBp(writedata, BP_MIN);
        end
    end

    assign common_split_select_d = (takeWr && hitCtrl && ctrlWrOk) ? writedata[COMMON_SPLIT_SELECT_POS]
                                                     : common_split_select_q;

    always_comb begin
        rdData_d = rdData_q;
        if (takeRd) begin
            rdData_d = RD_ZERO;
            if (hitCtrl) begin
                rdData_d[COMMON_SPLIT_SELECT_POS] = common_split_select_q;
            end else if (hitSplit) begin
                rdData_d[BP_W-1:0] = splitView;
            end else if (hitAlias && aliasOpen) begin
                rdData_d[BP_W-1:0] = nsBp_q;
            end else if (takeAck) begin
                rdData_d = ackWord;
            end
            // closed or missing aliases and unmapped words read zero
        end
    end

    // common_split_select with grouping hands group 1 to the secure copy
    assign g1SepMap = GROUPING && common_split_select_q;
    assign g1Bp     = g1SepMap ? sBp_q : nsBp_q;

    g1a_split_map u_g1_map (
        .binPoint  (g1Bp),
        .sepMap    (g1SepMap),
        .groupMask (g1MaskComb)
    );

    g1a_split_map u_g0_map (
        .binPoint  (sBp_q),
        .sepMap    (1'b0),
        .groupMask (g0MaskComb)
    );

    g1a_ack_port #(
        .MULTI_CPU (MULTI_CPU)
    ) u_ack (
        .ref_clk    (ref_clk),
        .rst_b      (rst_b),
        .takeAck    (takeAck),
        .group1Only (group1Only),
        .sigValid   (sigValid),
        .sigGroup1  (sigGroup1),
        .sigId      (sigId),
        .sigCpu     (sigCpu),
        .ackWord    (ackWord),
        .ackStrobe  (ackStrobe),
        .ackId      (ackId)
    );

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q  <= ST_IDLE;
            nsBp_q   <= ALIAS_RST;
            sBp_q    <= BP_MIN;
            common_split_select_q   <= RST_COMMON_SPLIT_SELECT;
            rdData_q <= RD_ZERO;
        end else begin
            state_q  <= state_d;
            nsBp_q   <= nsBp_d;
            sBp_q    <= sBp_d;
            common_split_select_q   <= common_split_select_d;
            rdData_q <= rdData_d;
        end
    end

    // masks are registered so preemption sees a glitch-free split
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            g1Mask_q     <= 8'h00;
            g0Mask_q     <= 8'h00;
            firstCycle_q <= 1'b1;
        end else begin
            g1Mask_q     <= g1MaskComb;
            g0Mask_q     <= g0MaskComb;
            firstCycle_q <= 1'b0;
        end
    end

    assign readdata          = rdData_q;
    assign group1PreemptMask = g1Mask_q;
    assign group0PreemptMask = g0Mask_q;

    property p_alias_reset;
        @(posedge ref_clk) disable iff (!rst_b)
        firstCycle_q |-> (nsBp_q == ALIAS_RST) && (nsBp_q >= BP_ONE)
                         && (nsBp_q <= 3'h4);
    endproperty
    a_alias_reset: assert property (p_alias_reset)
        else $error("alias binary point reset value wrong");

    property p_ns_alias_blocked;
        @(posedge ref_clk) disable iff (!rst_b)
        (takeWr && hitAlias && SEC_EXT && !secureAccess)
            |=> $stable(nsBp_q) ##1 (readdata == RD_ZERO || !$past(read));
    endproperty
    a_ns_alias_blocked: assert property (p_ns_alias_blocked)
        else $error("non-secure access changed the alias");

    property p_shared_store;
        @(posedge ref_clk) disable iff (!rst_b)
        (takeWr && hitAlias && aliasOpen)
            |=> nsBp_q == clampBp($past(writedata), ALIAS_RST);
    endproperty
    a_shared_store: assert property (p_shared_store)
        else $error("alias write not stored in shared copy");

    property p_ns_split_sees_alias;
        @(posedge ref_clk) disable iff (!rst_b)
        (takeRd && hitSplit && !splitSecure)
            |=> readdata == {29'h0, $past(nsBp_q)};
    endproperty
    a_ns_split_sees_alias: assert property (p_ns_split_sees_alias)
        else $error("non-secure split view differs from alias storage");

    property p_alias_read_common_split_select_free;
        @(posedge ref_clk) disable iff (!rst_b)
        (takeRd && hitAlias && aliasOpen)
            |=> readdata == {29'h0, $past(nsBp_q)};
    endproperty
    a_alias_read_common_split_select_free: assert property (p_alias_read_common_split_select_free)
        else $error("alias read depends on more than its storage");

    property p_common_split_select_isolates;
        @(posedge ref_clk) disable iff (!rst_b)
        (GROUPING && common_split_select_q && $stable(common_split_select_q) && $stable(sBp_q))
            |=> $stable(group1PreemptMask);
    endproperty
    a_common_split_select_isolates: assert property (p_common_split_select_isolates)
        else $error("alias steered group 1 preemption under common_split_select");

    property p_absent_raz;
        @(posedge ref_clk) disable iff (!rst_b)
        (takeRd && ((hitAlias && !aliasOpen) || (hitAckAlias && !ackAliasOpen)))
            |=> (readdata == RD_ZERO) && !ackStrobe;
    endproperty
    a_absent_raz: assert property (p_absent_raz)
        else $error("closed alias did not read zero");

    property p_split_map;
        @(posedge ref_clk) disable iff (!rst_b)
        (!common_split_select_q && $stable(nsBp_q) && $stable(common_split_select_q))
            |=> group1PreemptMask
                == (8'hff << ({1'b0, $past(nsBp_q)} + 4'h1));
    endproperty
    a_split_map: assert property (p_split_map)
        else $error("standard group priority mask wrong");

    property p_ack_id;
        @(posedge ref_clk) disable iff (!rst_b)
        (takeRd && hitAckAlias && ackAliasOpen && sigValid && sigGroup1)
            |=> readdata[ID_W-1:0] == $past(sigId) && ackStrobe
                && ackId == $past(sigId) ##1 !ackStrobe;
    endproperty
    a_ack_id: assert property (p_ack_id)
        else $error("acknowledge alias did not return and ack the id");

    property p_ack_no_group0;
        @(posedge ref_clk) disable iff (!rst_b)
        (takeRd && hitAckAlias && !(sigValid && sigGroup1))
            |=> readdata[ID_W-1:0] != $past(sigId) || !ackStrobe;
    endproperty
    a_ack_no_group0: assert property (p_ack_no_group0)
        else $error("acknowledge alias acked a non group 1 interrupt");

    property p_cpu_field;
        @(posedge ref_clk) disable iff (!rst_b)
        (takeAck && sigValid && sigId >= ID_SGI_LIMIT)
            |=> readdata[12:10] == 3'h0;
    endproperty
    a_cpu_field: assert property (p_cpu_field)
        else $error("requester field set for a non-sgi");

    property p_alias_reserved;
        @(posedge ref_clk) disable iff (!rst_b)
        (takeRd && (hitAlias || hitSplit)) |=> readdata[31:3] == 29'h0;
    endproperty
    a_alias_reserved: assert property (p_alias_reserved)
        else $error("reserved alias bits read nonzero");

    property p_answer_time;
        @(posedge ref_clk) disable iff (!rst_b)
        take |-> waitrequest ##1 !waitrequest;
    endproperty
    a_answer_time: assert property (p_answer_time)
        else $error("bus answer not one cycle after take");
endmodule

// File: bench/tb_top.sv
// self-checking bench for the group 1 alias register block
`timescale 1ns/1ps
`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin nFail++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module tb_top
    import g1a_pkg::*;
;
    logic              ref_clk;
    logic              rst_b;
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
    logic              secureAccess;
    logic              sigValid;
    logic              sigGroup1;
    logic [ID_W-1:0]   sigId;
    logic [CPU_W-1:0]  sigCpu;
    logic              ackStrobe;
    logic [ID_W-1:0]   ackId;
    logic [PRIO_W-1:0] group1PreemptMask;
    logic [PRIO_W-1:0] group0PreemptMask;
    logic [DATA_W-1:0] rdData2;
    logic              wait2;
    logic              strobe2;
    logic [DATA_W-1:0] rd;
    logic [DATA_W-1:0] rd2;
    logic              strb;
    logic              strb2;
    logic [ID_W-1:0]   aid;
    int                nFail;
    int                checked;

    g1a_regs DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .secureAccess(secureAccess),
        .sigValid(sigValid), .sigGroup1(sigGroup1), .sigId(sigId),
        .sigCpu(sigCpu), .ackStrobe(ackStrobe), .ackId(ackId),
        .group1PreemptMask(group1PreemptMask),
        .group0PreemptMask(group0PreemptMask));

    // second copy built without either alias; shares the bus, answers alike
    g1a_regs #(.VERSION(1), .SEC_EXT(1'b0)) uAbsent (
        .ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(rdData2),
        .waitrequest(wait2), .secureAccess(secureAccess),
        .sigValid(sigValid), .sigGroup1(sigGroup1), .sigId(sigId),
        .sigCpu(sigCpu), .ackStrobe(strobe2), .ackId(),
        .group1PreemptMask(), .group0PreemptMask());

    always #12.5 ref_clk = ~ref_clk;

    function automatic logic [PRIO_W-1:0] mexp(input int sh);
        return 8'hff << sh;
    endfunction

    // the request stands until the edge that samples waitrequest low; the
    // answer is taken at that edge, before the design updates its state
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a,
                       input logic sec, input logic [DATA_W-1:0] wd);
        int n;
        @(posedge ref_clk);
        address <= a;
        writedata <= wd;
        secureAccess <= sec;
        write <= w;
        read <= !w;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 40);
        if (n >= 40) begin
            nFail++;
            summarize();
        end
        rd = readdata;
        rd2 = rdData2;
        strb = ackStrobe;
        strb2 = strobe2;
        aid = ackId;
        `CHK(wait2, 1'b0)
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic sec,
                      input logic [DATA_W-1:0] wd);
        acc(1'b1, a, sec, wd);
    endtask

    task automatic rdc(input logic [ADDR_W-1:0] a, input logic sec,
                       input logic [DATA_W-1:0] e);
        acc(1'b0, a, sec, 32'h0000_0000);
        `CHK(rd, e)
    endtask

    // masks are registered from the stored points, so let them settle
    task automatic mchk(input logic [PRIO_W-1:0] e1,
                        input logic [PRIO_W-1:0] e0);
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        `CHK(group1PreemptMask, e1)
        `CHK(group0PreemptMask, e0)
    endtask

    task automatic sig(input logic v, input logic g1,
                       input logic [ID_W-1:0] id, input logic [CPU_W-1:0] c);
        @(posedge ref_clk);
        sigValid <= v;
        sigGroup1 <= g1;
        sigId <= id;
        sigCpu <= c;
    endtask

    task automatic ackCase(input logic [ADDR_W-1:0] a, input logic sec,
                           input logic v, input logic g1,
                           input logic [ID_W-1:0] id, input logic [CPU_W-1:0] c,
                           input logic [DATA_W-1:0] e, input logic hit);
        sig(v, g1, id, c);
        rdc(a, sec, e);
        `CHK(strb, hit)
        if (hit) `CHK(aid, id)
        @(negedge ref_clk);
        `CHK(ackStrobe, 1'b0)
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", checked, nFail);
        if (nFail == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge ref_clk);
        nFail++;
        summarize();
    end

    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        secureAccess = 1'b0;
        sigValid = 1'b0;
        sigGroup1 = 1'b0;
        sigId = '0;
        sigCpu = '0;
        nFail = 0;
        checked = 0;
        repeat (4) @(posedge ref_clk);
        rst_b <= 1'b1;
        rdc(OFF_ALIAS, 1'b1, {29'h0, BP_MIN_DEF + BP_ONE});
        rdc(OFF_SPLIT, 1'b0, {29'h0, BP_MIN_DEF + BP_ONE});
        rdc(OFF_SPLIT, 1'b1, {29'h0, BP_MIN_DEF});
        mchk(mexp(4), mexp(3));
        $display("test reset done");
        wr(OFF_ALIAS, 1'b1, 32'hffff_fffd);
        rdc(OFF_ALIAS, 1'b1, 32'h0000_0005);
        rdc(OFF_SPLIT, 1'b0, 32'h0000_0005);
        for (int bp = 3; bp < 8; bp++) begin
            wr(OFF_SPLIT, 1'b0, 32'(bp));
            rdc(OFF_ALIAS, 1'b1, 32'(bp));
            mchk(mexp(bp + 1), mexp(3));
        end
        $display("test shared storage done");
        rdc(OFF_ALIAS, 1'b0, 32'h0000_0000);
        wr(OFF_ALIAS, 1'b0, 32'h0000_0004);
        rdc(OFF_ALIAS, 1'b1, 32'h0000_0007);
        ackCase(OFF_ACK_ALIAS, 1'b0, 1'b1, 1'b1, 10'h025, 3'h0,
                32'h0000_0000, 1'b0);
        wr(8'h40, 1'b1, 32'hffff_ffff);
        rdc(8'h40, 1'b1, 32'h0000_0000);
        wr(OFF_ALIAS, 1'b1, 32'h0000_0000);
        rdc(OFF_ALIAS, 1'b1, {29'h0, BP_MIN_DEF + BP_ONE});
        $display("test security done");
        wr(OFF_CTRL, 1'b1, 32'h0000_0001);
        for (int bp = 2; bp < 8; bp++) begin
            wr(OFF_SPLIT, 1'b1, 32'(bp));
            mchk(mexp(bp), mexp(bp + 1));
        end
        wr(OFF_ALIAS, 1'b1, 32'h0000_0004);
        rdc(OFF_ALIAS, 1'b1, 32'h0000_0004);
        mchk(mexp(7), mexp(8));
        wr(OFF_CTRL, 1'b1, 32'h0000_0000);
        mchk(mexp(5), mexp(8));
        $display("test common select done");
        // pass 0 is the alias, pass 1 the non-secure normal view
        for (int j = 0; j < 2; j++) begin
            ackCase(j ? OFF_ACK : OFF_ACK_ALIAS, j == 0, 1'b1, 1'b1, 10'h025,
                    3'h3, 32'h0000_0025, 1'b1);
            ackCase(j ? OFF_ACK : OFF_ACK_ALIAS, j == 0, 1'b1, 1'b1, 10'h005,
                    3'h3, 32'h0000_0c05, 1'b1);
            ackCase(j ? OFF_ACK : OFF_ACK_ALIAS, j == 0, 1'b1, 1'b1, 10'h00f,
                    3'h7, 32'h0000_1c0f, 1'b1);
            ackCase(j ? OFF_ACK : OFF_ACK_ALIAS, j == 0, 1'b1, 1'b1, 10'h010,
                    3'h5, 32'h0000_0010, 1'b1);
            ackCase(j ? OFF_ACK : OFF_ACK_ALIAS, j == 0, 1'b1, 1'b0, 10'h030,
                    3'h0, {22'h0, ID_SPURIOUS}, 1'b0);
            ackCase(j ? OFF_ACK : OFF_ACK_ALIAS, j == 0, 1'b0, 1'b1, 10'h031,
                    3'h0, {22'h0, ID_SPURIOUS}, 1'b0);
        end
        $display("test acknowledge done");
        wr(OFF_ALIAS, 1'b1, 32'h0000_0006);
        rdc(OFF_ALIAS, 1'b1, 32'h0000_0006);
        `CHK(rd2, 32'h0000_0000)
        sig(1'b1, 1'b1, 10'h040, 3'h0);
        rdc(OFF_ACK_ALIAS, 1'b1, 32'h0000_0040);
        `CHK(rd2, 32'h0000_0000)
        `CHK(strb2, 1'b0)
        $display("test absent alias done");
        summarize();
    end
endmodule
